// *** verilog/assr_pkg.sv ***
`default_nettype none
// ============================================================================
// Shared constants and types of the sample status register bank.
package assr_pkg;

  // ==========================================================================
  // Widths and depths.
  localparam int BYTE_W    = 8;
  localparam int SAMPLE_W  = 10;
  localparam int AXES      = 3;
  localparam int ADDR_W    = 8;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_PTR_W = 1;
  localparam int BUF_CNT_W = 2;

  // ==========================================================================
  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_SAMPLE_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_X_HIGH       = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_X_LOW        = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_Y_HIGH       = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_Y_LOW        = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_Z_HIGH       = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_Z_LOW        = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_STEP        = 8'h01;
  localparam logic [AXES-1:0][ADDR_W-1:0] OFS_HIGH_TAB = {OFS_Z_HIGH, OFS_Y_HIGH, OFS_X_HIGH};
  localparam logic [AXES-1:0][ADDR_W-1:0] OFS_LOW_TAB  = {OFS_Z_LOW, OFS_Y_LOW, OFS_X_LOW};

  // ==========================================================================
  // Field layout and reset values.
  localparam int BIT_ALL_OW    = 7;
  localparam int BIT_OW_LO     = 4;
  localparam int BIT_ALL_RDY   = 3;
  localparam int BIT_RDY_LO    = 0;
  localparam int HIGH_LSB      = 2;
  localparam int LOW_BITS      = 2;
  localparam int LOW_PAD_W     = 6;
  localparam logic [BYTE_W-1:0]   ZERO_BYTE   = 8'h00;
  localparam logic [SAMPLE_W-1:0] ZERO_SAMPLE = 10'h000;
  localparam logic [AXES-1:0]     ZERO_AXES   = 3'h0;
  localparam logic [LOW_PAD_W-1:0] LOW_PAD    = 6'h00;

  // ==========================================================================
  // Types.
  typedef logic [AXES-1:0][SAMPLE_W-1:0] assr_axes_t;

  typedef enum logic [2:0] {
    CMD_LOAD = 3'b001,
    CMD_READ = 3'b010,
    CMD_STOP = 3'b100
  } assr_cmd_kind_t;

  typedef struct packed {
    assr_cmd_kind_t    kind;
    logic [ADDR_W-1:0] addr;
  } assr_cmd_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_WAIT = 2'b10
  } assr_eng_state_t;

endpackage
`default_nettype wire

// *** verilog/assr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Fresh set over unread data raises combined overwrite.
// - Combined overwrite drops after all active highs read.
// - Axis overwrite set when unread sample replaced.
// - Axis high byte read clears axis overwrite.
// - Combined ready rises on any enabled new sample.
// - Combined ready drops after all enabled highs read.
// - Axis ready set by each new axis sample.
// - Axis high byte read clears axis ready.
// - Status byte layout fixed, all flags reset zero.
// - Samples are current 10-bit two's-complement values.
// - High byte bits 9..2, low byte bits 1..0 on top.
// - Burst from status walks seven bytes in order.
// - Fast read skips low bytes, four-byte burst.
// - Low byte readable only right after its high.
// - High read freezes matching low byte bits.
// - Standby to active clears status and samples.
// - Address advances per burst read, stop discards it.
// - Active to standby keeps all register contents.
module assr_regs (
  // System clock domain.
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire logic                    sysCe,
  // Sensor core, same clock as sys_clk.
  input  wire logic                    newSample,
  input  wire assr_pkg::assr_axes_t    sampleIn,
  input  wire logic [assr_pkg::AXES-1:0] axisEnable,
  input  wire logic                    activeMode,
  input  wire logic                    fastRead,
  // Serial register port, link clock domain.
  input  wire logic                    linkClk,
  input  wire logic                    hostCmdValid,
  input  wire assr_pkg::assr_cmd_t     hostCmd,
  output var  logic                    hostCmdReady,
  input  wire logic                    hostDataTaken,
  output var  logic [assr_pkg::BYTE_W-1:0] hostRdData,
  output var  logic                    hostRdValid
);
  import assr_pkg::*;

  // ==========================================================================
  // Link domain: command capture and answer presentation.
  assr_cmd_t         cmdHold_reg;
  logic              reqTgl_reg;
  logic              ackSync1_reg;
  logic              ackSync2_reg;
  logic              dataSync1_reg;
  logic              dataSync2_reg;
  logic              dataSeen_reg;
  logic              takenTgl_reg;

  // Sys domain: crossing flops and engine state.
  logic              reqSync1_reg;
  logic              reqSync2_reg;
  logic              reqSeen_reg;
  logic              ackTgl_reg;
  logic              takenSync1_reg;
  logic              takenSync2_reg;
  logic              takenSeen_reg;
  assr_eng_state_t   engState_reg;
  logic [ADDR_W-1:0] addrPtr_reg;
  logic              activePrev_reg;

  // Sample bank and flags.
  assr_axes_t        sample_reg;
  logic [AXES-1:0]   axisReady_reg;
  logic [AXES-1:0]   axisOverwrite_reg;
  logic              allReady_reg;
  logic              allOverwrite_reg;
  logic [AXES-1:0]   lowOwner_reg;
  logic [AXES-1:0][LOW_BITS-1:0] lowHold_reg;

  // Two-entry answer buffer and sender.
  logic [BYTE_W-1:0] bufMem [BUF_DEPTH];
  logic [BUF_PTR_W-1:0] bufWr_reg;
  logic [BUF_PTR_W-1:0] bufRd_reg;
  logic [BUF_CNT_W-1:0] bufCnt_reg;
  logic [BYTE_W-1:0] sendData_reg;
  logic              sendTgl_reg;
  logic              sendBusy_reg;

  // ==========================================================================
  // Link side handshake terms.
  logic cmdAccept;
  logic dataPulse;
  logic dataTake;
  assign cmdAccept = hostCmdValid & hostCmdReady;
  assign dataPulse = dataSync2_reg ^ dataSeen_reg;
  assign dataTake  = hostDataTaken & hostRdValid;

  // A command is held steady in cmdHold_reg until the sys side toggles back,
  // so the multi-bit payload crosses without its own synchroniser.
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      cmdHold_reg  <= '{kind: CMD_STOP, addr: OFS_SAMPLE_FLAGS};
      reqTgl_reg   <= 1'b0;
      hostCmdReady <= 1'b0;
    end else begin
      if (cmdAccept) begin
        cmdHold_reg <= hostCmd;
      end
      reqTgl_reg   <= reqTgl_reg ^ cmdAccept;
      hostCmdReady <= cmdAccept ? 1'b0 : (reqTgl_reg == ackSync2_reg);
    end
  end

  // Toggle synchronisers into the link domain.
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      ackSync1_reg  <= 1'b0;
      ackSync2_reg  <= 1'b0;
      dataSync1_reg <= 1'b0;
      dataSync2_reg <= 1'b0;
      dataSeen_reg  <= 1'b0;
    end else begin
      ackSync1_reg  <= ackTgl_reg;
      ackSync2_reg  <= ackSync1_reg;
      dataSync1_reg <= sendTgl_reg;
      dataSync2_reg <= dataSync1_reg;
      dataSeen_reg  <= dataSync2_reg;
    end
  end

  // The answer byte stands until the host takes it; until then the sender
  // stays busy and the buffer behind it fills.
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      hostRdData   <= ZERO_BYTE;
      hostRdValid  <= 1'b0;
      takenTgl_reg <= 1'b0;
    end else begin
      if (dataPulse) begin
        hostRdData <= sendData_reg;
      end
      hostRdValid  <= dataPulse | (hostRdValid & ~hostDataTaken);
      takenTgl_reg <= takenTgl_reg ^ dataTake;
    end
  end

  // ==========================================================================
  // Sys side command decode.
  logic cmdPulse;
  logic cmdPending;
  logic isRead;
  logic isLoad;
  logic isStop;
  logic bufInReady;
  logic execCmd;
  logic execRead;
  assign cmdPulse   = reqSync2_reg ^ reqSeen_reg;
  assign cmdPending = (engState_reg == ENG_WAIT);
  assign isRead     = (cmdHold_reg.kind == CMD_READ);
  assign isLoad     = (cmdHold_reg.kind == CMD_LOAD);
  assign isStop     = (cmdHold_reg.kind == CMD_STOP);
  assign bufInReady = (bufCnt_reg != BUF_CNT_W'(BUF_DEPTH));
  // A read waits here while the answer buffer is full.
  assign execCmd    = cmdPending & (~isRead | bufInReady);
  assign execRead   = execCmd & isRead;

  // Mode change and sample arrival.
  logic enterActive;
  logic sampleTake;
  assign enterActive = activeMode & ~activePrev_reg;
  assign sampleTake  = newSample & activeMode & ~enterActive;

  // ==========================================================================
  // Per-axis flags, sample store and low-byte hold.
  logic [AXES-1:0] hiRead;
  logic [AXES-1:0] loAddr;
  logic [AXES-1:0] newAxis;
  logic [AXES-1:0] owSet;
  logic [AXES-1:0] axisReadyNext;
  logic [AXES-1:0] axisOverwriteNext;
  logic [AXES-1:0][BYTE_W-1:0] highByte;
  logic [AXES-1:0][BYTE_W-1:0] lowByte;

  genvar gi;
  generate
    for (gi = 0; gi < AXES; gi++) begin : g_axis
      assign hiRead[gi]  = execRead & (addrPtr_reg == OFS_HIGH_TAB[gi]);
      assign loAddr[gi]  = (addrPtr_reg == OFS_LOW_TAB[gi]);
      assign newAxis[gi] = sampleTake & axisEnable[gi];
      // An unread sample being replaced, unless its high byte goes out now.
      assign owSet[gi]   = newAxis[gi] & axisReady_reg[gi] & ~hiRead[gi];
      // A new sample in the clearing cycle keeps the flag set.
      assign axisReadyNext[gi]     = newAxis[gi] | (axisReady_reg[gi] & ~hiRead[gi]);
      assign axisOverwriteNext[gi] = owSet[gi] | (axisOverwrite_reg[gi] & ~hiRead[gi]);
      assign highByte[gi] = sample_reg[gi][SAMPLE_W-1:HIGH_LSB];
      // Low byte answers only while it belongs to the high byte just read.
      assign lowByte[gi]  = lowOwner_reg[gi] ? {lowHold_reg[gi], LOW_PAD} : ZERO_BYTE;

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          sample_reg[gi]        <= ZERO_SAMPLE;
          axisReady_reg[gi]     <= 1'b0;
          axisOverwrite_reg[gi] <= 1'b0;
          lowHold_reg[gi]       <= '0;
        end else if (sysCe) begin
          if (enterActive) begin
            sample_reg[gi]        <= ZERO_SAMPLE;
            axisReady_reg[gi]     <= 1'b0;
            axisOverwrite_reg[gi] <= 1'b0;
          end else begin
            if (newAxis[gi]) begin
              sample_reg[gi] <= sampleIn[gi];
            end
            axisReady_reg[gi]     <= axisReadyNext[gi];
            axisOverwrite_reg[gi] <= axisOverwriteNext[gi];
          end
          if (hiRead[gi]) begin
            lowHold_reg[gi] <= sample_reg[gi][LOW_BITS-1:0];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Combined flags: set by any enabled axis, held while any enabled axis
  // still waits for its high byte.
  logic anyNew;
  logic anyOw;
  logic enabledPending;
  logic allReadyNext;
  logic allOverwriteNext;
  assign anyNew           = |newAxis;
  assign anyOw            = |owSet;
  assign enabledPending   = |(axisReadyNext & axisEnable);
  assign allReadyNext     = anyNew | (allReady_reg & enabledPending);
  assign allOverwriteNext = anyOw | (allOverwrite_reg & enabledPending);

  // Leaving active mode touches nothing, so the bank keeps its contents.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      allReady_reg     <= 1'b0;
      allOverwrite_reg <= 1'b0;
      activePrev_reg   <= 1'b0;
    end else if (sysCe) begin
      activePrev_reg <= activeMode;
      if (enterActive) begin
        allReady_reg     <= 1'b0;
        allOverwrite_reg <= 1'b0;
      end else begin
        allReady_reg     <= allReadyNext;
        allOverwrite_reg <= allOverwriteNext;
      end
    end
  end

  // ==========================================================================
  // Read data selection by address.
  logic [BYTE_W-1:0] flagsByte;
  logic [BYTE_W-1:0] readByte;
  assign flagsByte = {allOverwrite_reg, axisOverwrite_reg, allReady_reg, axisReady_reg};
  assign readByte  = (addrPtr_reg == OFS_SAMPLE_FLAGS) ? flagsByte :
                     (addrPtr_reg == OFS_X_HIGH)       ? highByte[0] :
                     (addrPtr_reg == OFS_X_LOW)        ? lowByte[0] :
                     (addrPtr_reg == OFS_Y_HIGH)       ? highByte[1] :
                     (addrPtr_reg == OFS_Y_LOW)        ? lowByte[1] :
                     (addrPtr_reg == OFS_Z_HIGH)       ? highByte[2] :
                     (addrPtr_reg == OFS_Z_LOW)        ? lowByte[2] :
                                                         ZERO_BYTE;

  // Burst address sequence; outside the bank the pointer simply counts.
  logic [ADDR_W-1:0] seqNormal;
  logic [ADDR_W-1:0] seqFast;
  logic [ADDR_W-1:0] addrNext;
  assign seqNormal = (addrPtr_reg == OFS_Z_LOW) ? OFS_SAMPLE_FLAGS : addrPtr_reg + ADDR_STEP;
  assign seqFast   = (addrPtr_reg == OFS_SAMPLE_FLAGS) ? OFS_X_HIGH :
                     (addrPtr_reg == OFS_X_HIGH)       ? OFS_Y_HIGH :
                     (addrPtr_reg == OFS_Y_HIGH)       ? OFS_Z_HIGH :
                     (addrPtr_reg == OFS_X_LOW)        ? OFS_SAMPLE_FLAGS :
                     (addrPtr_reg == OFS_Y_LOW)        ? OFS_SAMPLE_FLAGS :
                     (addrPtr_reg == OFS_Z_HIGH)       ? OFS_SAMPLE_FLAGS :
                     (addrPtr_reg == OFS_Z_LOW)        ? OFS_SAMPLE_FLAGS :
                                                         seqNormal;
  assign addrNext  = fastRead ? seqFast : seqNormal;

  // ==========================================================================
  // Command engine: one command at a time, acknowledged once carried out.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reqSync1_reg <= 1'b0;
      reqSync2_reg <= 1'b0;
      reqSeen_reg  <= 1'b0;
      ackTgl_reg   <= 1'b0;
      engState_reg <= ENG_IDLE;
    end else if (sysCe) begin
      reqSync1_reg <= reqTgl_reg;
      reqSync2_reg <= reqSync1_reg;
      ackTgl_reg   <= ackTgl_reg ^ execCmd;
      case (engState_reg)
        ENG_IDLE: begin
          if (cmdPulse) begin
            reqSeen_reg  <= reqSync2_reg;
            engState_reg <= ENG_WAIT;
          end
        end
        ENG_WAIT: begin
          if (execCmd) begin
            engState_reg <= ENG_IDLE;
          end
        end
        default: begin
          engState_reg <= ENG_IDLE;
        end
      endcase
    end
  end

  // Address pointer and low-byte ownership; a stop drops the burst address.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addrPtr_reg  <= OFS_SAMPLE_FLAGS;
      lowOwner_reg <= ZERO_AXES;
    end else if (sysCe) begin
      if (enterActive) begin
        lowOwner_reg <= ZERO_AXES;
      end else if (execCmd) begin
        lowOwner_reg <= hiRead;
      end
      if (execCmd && isLoad) begin
        addrPtr_reg <= cmdHold_reg.addr;
      end else if (execCmd && isStop) begin
        addrPtr_reg <= OFS_SAMPLE_FLAGS;
      end else if (execRead) begin
        addrPtr_reg <= addrNext;
      end
    end
  end

  // ==========================================================================
  // Two-entry answer buffer; its drain stalls while the link holds a byte.
  logic bufOutValid;
  logic bufOutReady;
  logic bufPush;
  logic bufPop;
  assign bufOutValid = (bufCnt_reg != '0);
  assign bufOutReady = ~sendBusy_reg;
  assign bufPush     = execRead;
  assign bufPop      = bufOutValid & bufOutReady;

  always_ff @(posedge sys_clk) begin
    if (sysCe && bufPush) begin
      bufMem[bufWr_reg] <= readByte;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bufWr_reg  <= '0;
      bufRd_reg  <= '0;
      bufCnt_reg <= '0;
    end else if (sysCe) begin
      bufWr_reg  <= bufWr_reg + BUF_PTR_W'(bufPush);
      bufRd_reg  <= bufRd_reg + BUF_PTR_W'(bufPop);
      bufCnt_reg <= bufCnt_reg + BUF_CNT_W'(bufPush) - BUF_CNT_W'(bufPop);
    end
  end

  // Sender: the byte is held until the link side toggles back.
  logic takenPulse;
  assign takenPulse = takenSync2_reg ^ takenSeen_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sendData_reg   <= ZERO_BYTE;
      sendTgl_reg    <= 1'b0;
      sendBusy_reg   <= 1'b0;
      takenSync1_reg <= 1'b0;
      takenSync2_reg <= 1'b0;
      takenSeen_reg  <= 1'b0;
    end else if (sysCe) begin
      takenSync1_reg <= takenTgl_reg;
      takenSync2_reg <= takenSync1_reg;
      takenSeen_reg  <= takenSync2_reg;
      if (bufPop) begin
        sendData_reg <= bufMem[bufRd_reg];
      end
      sendTgl_reg  <= sendTgl_reg ^ bufPop;
      sendBusy_reg <= bufPop | (sendBusy_reg & ~takenPulse);
    end
  end

endmodule
`default_nettype wire

// *** testbench/assr_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Link port checks of the sample register bank.
module assr_regs_asserts (
  // Link clock and reset.
  input wire logic                          linkClk,
  input wire logic                          arst_n,
  // Command channel.
  input wire logic                          hostCmdValid,
  input wire assr_pkg::assr_cmd_t           hostCmd,
  input wire logic                          hostCmdReady,
  // Answer channel.
  input wire logic                          hostDataTaken,
  input wire logic [assr_pkg::BYTE_W-1:0]   hostRdData,
  input wire logic                          hostRdValid
);
  import assr_pkg::*;
  logic [2:0] pendCount_reg;
  logic [2:0] pendCount_next;
  wire logic  cmdTaken  = hostCmdValid && hostCmdReady;
  wire logic  readTaken = cmdTaken && hostCmd.kind == CMD_READ;
  wire logic  byteTaken = hostRdValid && hostDataTaken;
  // Reads accepted but not handed over; a byte with none pending is a stray.
  assign pendCount_next = pendCount_reg + 3'(readTaken) - 3'(byteTaken);
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      pendCount_reg <= 3'h0;
    end else begin
      pendCount_reg <= pendCount_next;
    end
  end
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!arst_n);
  property p_reset_idle; !$past(arst_n) |-> !hostRdValid && !hostCmdReady && hostRdData == ZERO_BYTE; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link outputs not idle after reset");
  property p_hold; hostRdValid && !hostDataTaken |=> hostRdValid && $stable(hostRdData); endproperty
  a_hold: assert property (p_hold) else $error("answer byte changed before taken");
  property p_drop; byteTaken |=> !hostRdValid; endproperty
  a_drop: assert property (p_drop) else $error("answer byte stayed after take");
  property p_stray; hostRdValid |-> pendCount_reg != 3'h0; endproperty
  a_stray: assert property (p_stray) else $error("answer byte without a read");
  property p_answer; readTaken && pendCount_reg == 3'h0 |-> ##[1:30] hostRdValid; endproperty
  a_answer: assert property (p_answer) else $error("read not answered in time");
  property p_busy; cmdTaken |=> !hostCmdReady; endproperty
  a_busy: assert property (p_busy) else $error("ready stayed after accept");
  property p_back; cmdTaken && hostCmd.kind != CMD_READ |-> ##[1:20] hostCmdReady; endproperty
  a_back: assert property (p_back) else $error("load or stop not finished in time");
  property p_stay; hostCmdReady && !hostCmdValid |=> hostCmdReady; endproperty
  a_stay: assert property (p_stay) else $error("ready dropped without command");
endmodule
bind assr_regs assr_regs_asserts assr_regs_asserts_i (
  .linkClk(linkClk),
  .arst_n(arst_n),
  .hostCmdValid(hostCmdValid),
  .hostCmd(hostCmd),
  .hostCmdReady(hostCmdReady),
  .hostDataTaken(hostDataTaken),
  .hostRdData(hostRdData),
  .hostRdValid(hostRdValid)
);
`default_nettype wire

// *** testbench/assr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host controller on the serial register port.
module assr_host_model (
  // Link clock.
  input  wire logic                        linkClk,
  // Command channel.
  output var  logic                        hostCmdValid,
  output var  assr_pkg::assr_cmd_t         hostCmd,
  input  wire logic                        hostCmdReady,
  // Answer channel.
  output var  logic                        hostDataTaken,
  input  wire logic [assr_pkg::BYTE_W-1:0] hostRdData,
  input  wire logic                        hostRdValid
);
  import assr_pkg::*;
  int takeDelay = 0;
  // Idle at time zero.
  initial begin
    hostCmdValid = 1'b0;
    hostCmd = '{CMD_STOP, 8'h00};
    hostDataTaken = 1'b0;
  end
  // One command in flight; the address turns over when released so no stale value lingers.
  // A port that never answers is left to the bench watchdog, which fails the run.
  task automatic send(input assr_cmd_kind_t kind, input logic [7:0] addr);
    @(posedge linkClk);
    hostCmdValid <= 1'b1;
    hostCmd <= '{kind, addr};
    do @(posedge linkClk); while (!hostCmdReady);
    hostCmdValid <= 1'b0;
    hostCmd <= '{CMD_STOP, ~addr};
  endtask
  // Waits for a byte, stalls takeDelay edges, then takes it at one edge.
  task automatic get(output logic [7:0] data);
    do @(posedge linkClk); while (!hostRdValid);
    repeat (takeDelay) @(posedge linkClk);
    hostDataTaken <= 1'b1;
    @(posedge linkClk);
    data = hostRdData;
    hostDataTaken <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_assr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Register bank bench.
module tb_assr_regs;
  import assr_pkg::*;
  logic            sys_clk = 1'b0;
  logic            linkClk = 1'b0;
  logic            arst_n = 1'b0;
  logic            sysCe = 1'b1;
  logic            newSample = 1'b0;
  logic            activeMode = 1'b0;
  logic            fastRead = 1'b0;
  assr_axes_t      sampleIn = 30'h0;
  logic [AXES-1:0] axisEnable = 3'h7;
  logic            hostCmdValid;
  assr_cmd_t       hostCmd;
  logic            hostCmdReady;
  logic            hostDataTaken;
  logic [7:0]      hostRdData;
  logic            hostRdValid;
  logic [7:0]      d;
  logic [7:0]      burst [7] = '{8'h0F, 8'hA9, 8'h40, 8'h55, 8'h40, 8'hFF, 8'hC0};
  logic [7:0]      fast [5] = '{8'hFF, 8'h40, 8'h80, 8'h20, 8'h00};
  int              fail_count = 0;
  int              checked = 0;
  // Clocks; the link clock is offset so the two never share edges.
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #7;
    forever #40 linkClk = ~linkClk;
  end
  assr_regs assr_regs_i (.sys_clk(sys_clk), .arst_n(arst_n), .sysCe(sysCe), .newSample(newSample),
    .sampleIn(sampleIn), .axisEnable(axisEnable), .activeMode(activeMode), .fastRead(fastRead),
    .linkClk(linkClk), .hostCmdValid(hostCmdValid), .hostCmd(hostCmd), .hostCmdReady(hostCmdReady),
    .hostDataTaken(hostDataTaken), .hostRdData(hostRdData), .hostRdValid(hostRdValid));
  assr_host_model assr_host_model_i (.linkClk(linkClk), .hostCmdValid(hostCmdValid), .hostCmd(hostCmd),
    .hostCmdReady(hostCmdReady), .hostDataTaken(hostDataTaken), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid));
  // Byte comparison.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %02h seen %02h", what, exp, got);
    end
  endtask
  // One sample set from the sensor core.
  task automatic sample(input logic [9:0] x, input logic [9:0] y, input logic [9:0] z);
    @(posedge sys_clk);
    newSample <= 1'b1;
    sampleIn <= {z, y, x};
    @(posedge sys_clk);
    newSample <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rdb(input string what, input logic [7:0] exp);
    assr_host_model_i.send(CMD_READ, 8'h00);
    assr_host_model_i.get(d);
    chk(what, exp, d);
  endtask
  task automatic rd(input logic [7:0] a, input string what, input logic [7:0] exp);
    assr_host_model_i.send(CMD_LOAD, a);
    rdb(what, exp);
    assr_host_model_i.send(CMD_STOP, 8'h00);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge linkClk);
    rd(OFS_SAMPLE_FLAGS, "status after reset", 8'h00);
    @(posedge sys_clk);
    activeMode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    $display("test reset done");
    sample(10'h2A5, 10'h155, 10'h3FF);
    assr_host_model_i.send(CMD_LOAD, OFS_SAMPLE_FLAGS);
    repeat (4) assr_host_model_i.send(CMD_READ, 8'h00);
    repeat (30) @(posedge linkClk);
    chk("ready while full", 8'h00, {7'h00, hostCmdReady});
    assr_host_model_i.takeDelay = 3;
    for (int i = 0; i < 4; i++) begin
      assr_host_model_i.get(d);
      chk("burst byte", burst[i], d);
    end
    assr_host_model_i.takeDelay = 0;
    for (int i = 4; i < 7; i++) rdb("burst byte", burst[i]);
    assr_host_model_i.send(CMD_STOP, 8'h00);
    rd(OFS_SAMPLE_FLAGS, "status after highs", 8'h00);
    rd(8'h07, "unmapped", 8'h00);
    rd(OFS_X_LOW, "lone low byte", 8'h00);
    $display("test burst done");
    @(posedge sys_clk);
    axisEnable <= 3'h1;
    sample(10'h101, 10'h000, 10'h000);
    sample(10'h0FE, 10'h000, 10'h000);
    rd(OFS_SAMPLE_FLAGS, "status overwrite", 8'h99);
    rd(OFS_X_HIGH, "x high", 8'h3F);
    rd(OFS_SAMPLE_FLAGS, "status after x high", 8'h00);
    $display("test overwrite done");
    @(posedge sys_clk);
    axisEnable <= 3'h7;
    sample(10'h003, 10'h000, 10'h000);
    assr_host_model_i.send(CMD_LOAD, OFS_X_HIGH);
    rdb("x high", 8'h00);
    sample(10'h000, 10'h000, 10'h000);
    rdb("x low held", 8'hC0);
    assr_host_model_i.send(CMD_STOP, 8'h00);
    rd(OFS_SAMPLE_FLAGS, "status mixed", 8'hEF);
    $display("test coherency done");
    @(posedge sys_clk);
    fastRead <= 1'b1;
    sample(10'h100, 10'h200, 10'h080);
    assr_host_model_i.send(CMD_LOAD, OFS_SAMPLE_FLAGS);
    for (int i = 0; i < 5; i++) rdb("fast byte", fast[i]);
    assr_host_model_i.send(CMD_STOP, 8'h00);
    @(posedge sys_clk);
    fastRead <= 1'b0;
    $display("test fast done");
    sample(10'h3FC, 10'h000, 10'h000);
    @(posedge sys_clk);
    activeMode <= 1'b0;
    rd(OFS_SAMPLE_FLAGS, "status standby", 8'h0F);
    rd(OFS_X_HIGH, "x high standby", 8'hFF);
    rdb("read after stop", 8'h0E);
    assr_host_model_i.send(CMD_STOP, 8'h00);
    @(posedge sys_clk);
    activeMode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(OFS_X_HIGH, "x high restart", 8'h00);
    rd(OFS_SAMPLE_FLAGS, "status restart", 8'h00);
    // A sample offered while the clock enable is low must leave no trace.
    @(posedge sys_clk);
    sysCe <= 1'b0;
    sample(10'h1FF, 10'h1FF, 10'h1FF);
    sysCe <= 1'b1;
    rd(OFS_SAMPLE_FLAGS, "status frozen", 8'h00);
    $display("test modes done");
    close_out();
  end
  // Watchdog, well beyond the expected run of some tens of microseconds.
  initial begin
    #400000;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
